// File: src/local_remote_control_bits.sv
// local (panel) and remote (serial) control bits for control logic
// assumes requests come from same-clock command logic; label presence
// flags are settings levels, applied when settings_load pulses
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_bits_cfg.svh"

module local_remote_control_bits
#(
	parameter int N               = `CFG_SWITCHES,
	parameter int INTERVAL_CYCLES = `CFG_INTERVAL_CLKS
)
(
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     clk_en,
	// front-panel requests
	input  wire logic                     panel_req,
	input  wire logic [$clog2(N)-1:0]     panel_sel,
	input  wire ctrl_bits_pkg::sw_pos_t   panel_pos,
	// serial remote bit commands
	input  wire logic                     serial_bit_control_command,
	input  wire logic [$clog2(N)-1:0]     cmd_sel,
	input  wire ctrl_bits_pkg::sw_pos_t   cmd_pos,
	// label presence settings
	input  wire logic [N-1:0]             switch_name_label,
	input  wire logic [N-1:0]             switch_off_label,
	input  wire logic [N-1:0]             switch_on_label,
	input  wire logic [N-1:0]             switch_pulse_label,
	input  wire logic                     settings_load,
	// control bits and status
	output var  logic [N-1:0]             panel_switch_bit,
	output var  logic [N-1:0]             serial_switch_bit,
	output var  logic                     interval_tick,
	output var  logic                     restore_busy
);

	import ctrl_bits_pkg::*;

	localparam int IW = $clog2(N);
	localparam logic [IW-1:0] LAST_IDX = IW'(N - 1);

	// a switch is usable only with name, off and at least one active label
	function automatic logic sw_enabled(input logic nm, input logic off,
		input logic on, input logic pls);
		sw_enabled = nm & off & (on | pls);
	endfunction : sw_enabled

	// per-position legality against the applied labels
	function automatic logic pos_allowed(input sw_pos_t pos,
		input logic en, input logic on, input logic pls);
		unique case (pos)
			POS_OFF: pos_allowed = en;
			POS_ON:  pos_allowed = en & on;
			POS_MOM: pos_allowed = en & pls;
			default: pos_allowed = 1'h0;
		endcase
	endfunction : pos_allowed

	logic          tick;
	logic [N-1:0]  lbl_en;
	logic          mem_rd_bit;

	// switch type decode from present labels
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_type
			assign lbl_en[gi] = sw_enabled(switch_name_label[gi],
				switch_off_label[gi], switch_on_label[gi],
				switch_pulse_label[gi]);
		end
	endgenerate

	interval_timer
	#(
		.CYCLES (INTERVAL_CYCLES)
	)
	u_timer
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.tick    (tick)
	);

	// restore sequencer and retained-store scan
	restore_state_t state_r;
	restore_state_t state_nxt;
	logic [IW-1:0]  idx_r;
	logic [IW-1:0]  idx_nxt;
	logic [IW-1:0]  cap_idx_r;
	logic [IW-1:0]  cap_idx_nxt;
	logic           cap_vld_r;
	logic           cap_vld_nxt;
	logic [IW-1:0]  wr_idx_r;
	logic [IW-1:0]  wr_idx_nxt;
	logic           running;

	assign running = (state_r == ST_RUN);

	always_comb
	begin
		state_nxt   = state_r;
		idx_nxt     = idx_r;
		cap_idx_nxt = idx_r;
		cap_vld_nxt = 1'h0;
		wr_idx_nxt  = wr_idx_r;
		unique case (state_r)
			ST_LOAD:
			begin
				cap_vld_nxt = 1'h1;
				idx_nxt     = idx_r + IW'(1);
				if (idx_r == LAST_IDX)
					state_nxt = ST_DRAIN;
			end
			ST_DRAIN:
				state_nxt = ST_RUN;
			ST_RUN:
				wr_idx_nxt = (wr_idx_r == LAST_IDX) ? '0 : wr_idx_r + IW'(1);
			default:
				state_nxt = ST_LOAD;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_r   <= ST_LOAD;
			idx_r     <= '0;
			cap_idx_r <= '0;
			cap_vld_r <= 1'h0;
			wr_idx_r  <= '0;
		end
		else if (clk_en)
		begin
			state_r   <= state_nxt;
			idx_r     <= idx_nxt;
			cap_idx_r <= cap_idx_nxt;
			cap_vld_r <= cap_vld_nxt;
			wr_idx_r  <= wr_idx_nxt;
		end
	end

	// local bits
	logic [N-1:0] lhold_r;
	logic [N-1:0] lhold_nxt;
	logic [N-1:0] lpend_r;
	logic [N-1:0] lpend_nxt;
	logic [N-1:0] en_r;
	logic [N-1:0] en_nxt;
	logic [N-1:0] on_r;
	logic [N-1:0] on_nxt;
	logic [N-1:0] pls_r;
	logic [N-1:0] pls_nxt;
	logic [N-1:0] lout_r;
	logic [N-1:0] lout_nxt;

	// scanned write-through: a change reaches storage within N cycles,
	// traded against a per-change write queue
	nv_bit_store
	#(
		.WIDTH (1),
		.DEPTH (N)
	)
	u_store
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.wr_en   (running),
		.wr_addr (wr_idx_r),
		.wr_data (lhold_r[wr_idx_r]),
		.rd_en   (state_r == ST_LOAD),
		.rd_addr (idx_r),
		.rd_data (mem_rd_bit)
	);

	always_comb
	begin
		lhold_nxt = lhold_r;
		lpend_nxt = lpend_r & ~{N{tick}};
		en_nxt    = en_r;
		on_nxt    = on_r;
		pls_nxt   = pls_r;
		lout_nxt  = lout_r;
		if (!running)
		begin
			lpend_nxt = '0;
			lout_nxt  = '0;
			// retained state comes back, but only for usable switches
			if (cap_vld_r)
				lhold_nxt[cap_idx_r] = mem_rd_bit & lbl_en[cap_idx_r];
			if (state_r == ST_DRAIN)
			begin
				en_nxt  = lbl_en;
				on_nxt  = switch_on_label;
				pls_nxt = switch_pulse_label;
			end
		end
		else if (settings_load)
		begin
			// unchanged usability keeps the state; anything else starts at 0
			for (int i = 0; i < N; i++)
			begin
				if (!lbl_en[i])
				begin
					lhold_nxt[i] = 1'h0;
					lpend_nxt[i] = 1'h0;
				end
				else if (!en_r[i])
				begin
					lhold_nxt[i] = 1'h0;
					lpend_nxt[i] = 1'h0;
				end
			end
			lout_nxt = (tick ? (lhold_r | lpend_r) : lout_r)
				& lbl_en & en_r;
			en_nxt   = lbl_en;
			on_nxt   = switch_on_label;
			pls_nxt  = switch_pulse_label;
		end
		else
		begin
			if (panel_req && pos_allowed(panel_pos, en_r[panel_sel],
				on_r[panel_sel], pls_r[panel_sel]))
			begin
				unique case (panel_pos)
					POS_ON:
						lhold_nxt[panel_sel] = 1'h1;
					POS_MOM:
					begin
						lhold_nxt[panel_sel] = 1'h0;
						lpend_nxt[panel_sel] = 1'h1;
					end
					default:
						lhold_nxt[panel_sel] = 1'h0;
				endcase
			end
			// a pending pulse shows for exactly one interval
			if (tick)
				lout_nxt = (lhold_r | lpend_r) & en_r;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			lhold_r <= '0;
			lpend_r <= '0;
			en_r    <= '0;
			on_r    <= '0;
			pls_r   <= '0;
			lout_r  <= '0;
		end
		else if (clk_en)
		begin
			lhold_r <= lhold_nxt;
			lpend_r <= lpend_nxt;
			en_r    <= en_nxt;
			on_r    <= on_nxt;
			pls_r   <= pls_nxt;
			lout_r  <= lout_nxt;
		end
	end

	// remote bits: only the serial command path reaches them
	logic [N-1:0] rhold_r;
	logic [N-1:0] rhold_nxt;
	logic [N-1:0] rpend_r;
	logic [N-1:0] rpend_nxt;
	logic [N-1:0] rout_r;
	logic [N-1:0] rout_nxt;

	always_comb
	begin
		rhold_nxt = rhold_r;
		rpend_nxt = rpend_r & ~{N{tick}};
		rout_nxt  = rout_r;
		if (serial_bit_control_command)
		begin
			unique case (cmd_pos)
				POS_ON:
					rhold_nxt[cmd_sel] = 1'h1;
				POS_OFF:
					rhold_nxt[cmd_sel] = 1'h0;
				POS_MOM:
				begin
					rhold_nxt[cmd_sel] = 1'h0;
					rpend_nxt[cmd_sel] = 1'h1;
				end
				default:
					rhold_nxt = rhold_r;
			endcase
		end
		if (tick)
			rout_nxt = rhold_r | rpend_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rhold_r <= {N{`CFG_BIT_RESET}};
			rpend_r <= '0;
			rout_r  <= {N{`CFG_BIT_RESET}};
		end
		else if (clk_en)
		begin
			rhold_r <= rhold_nxt;
			rpend_r <= rpend_nxt;
			rout_r  <= rout_nxt;
		end
	end

	assign panel_switch_bit  = lout_r;
	assign serial_switch_bit = rout_r;
	assign interval_tick     = tick;
	assign restore_busy      = !running;

endmodule : local_remote_control_bits

`default_nettype wire

// File: shared/ctrl_bits_cfg.svh
// constants for the local/remote control bit block
// assumes a single system clock whose rate is given below
`ifndef CTRL_BITS_CFG_SVH
`define CTRL_BITS_CFG_SVH

`define CFG_SWITCHES      16
`define CFG_SYS_CLK_HZ    250000000
`define CFG_POWER_HZ      60
// processing interval is 1/4 of a power-system cycle
`define CFG_INTERVAL_DEN  4
`define CFG_INTERVAL_CLKS (`CFG_SYS_CLK_HZ / (`CFG_POWER_HZ * `CFG_INTERVAL_DEN))
`define CFG_BIT_RESET     1'h0

`endif

// File: shared/ctrl_bits_pkg.sv
// types shared by the control bit block and its helpers
// assumes nothing of its surroundings
package ctrl_bits_pkg;

	typedef enum logic [1:0]
	{
		POS_OFF = 2'h0,
		POS_ON  = 2'h1,
		POS_MOM = 2'h2,
		POS_BAD = 2'h3
	} sw_pos_t;

	typedef enum logic [1:0]
	{
		ST_LOAD  = 2'h0,
		ST_DRAIN = 2'h1,
		ST_RUN   = 2'h2
	} restore_state_t;

endpackage : ctrl_bits_pkg

// File: src/interval_timer.sv
// processing interval tick generator
// assumes sys_clk at the configured rate; tick is one clock wide
`timescale 1ns/1ps
`default_nettype none

module interval_timer
#(
	parameter int CYCLES = 1041666
)
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// interval boundary
	output var  logic tick
);

	localparam int CW = $clog2(CYCLES);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          tick_r;
	logic          tick_nxt;

	always_comb
	begin
		tick_nxt = (cnt_r == CW'(CYCLES - 1));
		cnt_nxt  = tick_nxt ? '0 : cnt_r + CW'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cnt_r  <= '0;
			tick_r <= 1'h0;
		end
		else if (clk_en)
		begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule : interval_timer

`default_nettype wire

// File: src/nv_bit_store.sv
// small retained store for switch states
// the array has no reset: it stands for storage kept across power loss
`timescale 1ns/1ps
`default_nettype none

module nv_bit_store
#(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
)
(
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic                     clk_en,
	// write side
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	// read side, one cycle latency
	input  wire logic                     rd_en,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output var  logic [WIDTH-1:0]         rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_r;

	always_ff @(posedge sys_clk)
	begin
		if (clk_en && wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rd_data_r <= '0;
		else if (clk_en && rd_en)
			rd_data_r <= mem[rd_addr];
	end

	assign rd_data = rd_data_r;

endmodule : nv_bit_store

`default_nettype wire

// File: dv/lrcb_monitor.sv
// checker for the local and remote control bit block
// assumes interval timing is judged in enabled clocks only
`timescale 1ns/1ps
`default_nettype none

module lrcb_monitor
#(
	parameter int N               = 16,
	parameter int INTERVAL_CYCLES = 8
)
(
	// clock and reset
	input wire logic         sys_clk,
	input wire logic         rst,
	input wire logic         clk_en,
	// settings
	input wire logic [N-1:0] switch_name_label,
	input wire logic [N-1:0] switch_off_label,
	input wire logic [N-1:0] switch_on_label,
	input wire logic [N-1:0] switch_pulse_label,
	input wire logic         settings_load,
	// watched outputs
	input wire logic [N-1:0] panel_switch_bit,
	input wire logic [N-1:0] serial_switch_bit,
	input wire logic         interval_tick,
	input wire logic         restore_busy
);
	wire logic [N-1:0] en;
	int                cnt_r;
	logic              seen_r;

	assign en = switch_name_label & switch_off_label
		& (switch_on_label | switch_pulse_label);

	// enabled clocks since the last tick
	always_ff @(posedge sys_clk)
		if (rst)
		begin
			cnt_r <= 0;
			seen_r <= 1'h0;
		end
		else if (clk_en)
		begin
			cnt_r <= interval_tick ? 0 : cnt_r + 1;
			seen_r <= seen_r | interval_tick;
		end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_remote_reset: assert property (
		$fell(rst) |-> serial_switch_bit == '0)
		else $error("remote bits not cleared by reset");
	a_busy_release: assert property (
		$fell(rst) |-> ##16 restore_busy ##1 !restore_busy)
		else $error("restore length wrong");
	a_panel_hold: assert property (
		!$past(interval_tick) && !$past(settings_load)
		&& !$past(restore_busy) && !$past(rst) |-> $stable(panel_switch_bit))
		else $error("local bits moved off a tick");
	a_remote_hold: assert property (
		!$past(interval_tick) && !$past(rst) |-> $stable(serial_switch_bit))
		else $error("remote bits moved off a tick");
	a_tick_period: assert property (
		seen_r && interval_tick |-> cnt_r == INTERVAL_CYCLES - 1)
		else $error("interval length wrong");
	a_tick_bound: assert property (
		cnt_r <= INTERVAL_CYCLES)
		else $error("interval tick missing");
	a_settings_clear: assert property (
		$past(settings_load) && !$past(restore_busy)
		|-> (panel_switch_bit & ~en) == '0)
		else $error("disabled switch bit not zero");
	a_new_zero: assert property (
		$past(settings_load) && !$past(restore_busy)
		|-> (panel_switch_bit & en & ~$past(en, 2)) == '0)
		else $error("new switch bit not zero");
endmodule : lrcb_monitor

bind local_remote_control_bits lrcb_monitor
	#(.N(N), .INTERVAL_CYCLES(INTERVAL_CYCLES)) u_lrcb_monitor
	(.sys_clk, .rst, .clk_en, .switch_name_label, .switch_off_label,
	.switch_on_label, .switch_pulse_label, .settings_load,
	.panel_switch_bit, .serial_switch_bit, .interval_tick, .restore_busy);
`default_nettype wire

// File: dv/cmd_source.sv
// keypad and serial command model feeding the block's request ports
// assumes one caller at a time; each request is a one-clock pulse
`timescale 1ns/1ps
`default_nettype none

module cmd_source
(
	// clock
	input  wire logic             sys_clk,
	// keypad side
	output var  logic             panel_req,
	output var  logic [3:0]       panel_sel,
	output var  ctrl_bits_pkg::sw_pos_t panel_pos,
	// serial side
	output var  logic             serial_bit_control_command,
	output var  logic [3:0]       cmd_sel,
	output var  ctrl_bits_pkg::sw_pos_t cmd_pos
);
	import ctrl_bits_pkg::*;

	initial
	begin
		panel_req = 1'h0;
		panel_sel = 4'h0;
		panel_pos = POS_OFF;
		serial_bit_control_command = 1'h0;
		cmd_sel = 4'h0;
		cmd_pos = POS_OFF;
	end

	// keypad never reaches the remote bits
	task press(input logic [3:0] s, input sw_pos_t p);
		@(posedge sys_clk);
		panel_req <= 1'h1;
		panel_sel <= s;
		panel_pos <= p;
		@(posedge sys_clk);
		panel_req <= 1'h0;
		panel_sel <= ~s;
	endtask : press

	task send(input logic [3:0] s, input sw_pos_t p);
		@(posedge sys_clk);
		serial_bit_control_command <= 1'h1;
		cmd_sel <= s;
		cmd_pos <= p;
		@(posedge sys_clk);
		serial_bit_control_command <= 1'h0;
		cmd_sel <= ~s;
	endtask : send
endmodule : cmd_source
`default_nettype wire

// File: dv/local_remote_control_bits_tb.sv
// self-checking bench for the local and remote control bits
// assumes an interval of 8 clocks so ticks come often
`timescale 1ns/1ps
`default_nettype none

module local_remote_control_bits_tb;
	import ctrl_bits_pkg::*;
	logic        sys_clk = 1'h0;
	logic        rst = 1'h1;
	logic        clk_en = 1'h1;
	logic        settings_load = 1'h0;
	logic [15:0] switch_name_label = 16'h0;
	logic [15:0] switch_off_label = 16'h0;
	logic [15:0] switch_on_label = 16'h0;
	logic [15:0] switch_pulse_label = 16'h0;
	logic        panel_req, serial_bit_control_command;
	logic [3:0]  panel_sel, cmd_sel;
	sw_pos_t     panel_pos, cmd_pos;
	logic [15:0] panel_switch_bit, serial_switch_bit;
	logic        interval_tick, restore_busy;
	int          errors = 0;
	int          compares = 0;

	always #2 sys_clk = ~sys_clk;

	local_remote_control_bits #(.INTERVAL_CYCLES(8))
		u_local_remote_control_bits
		(.sys_clk, .rst, .clk_en, .panel_req, .panel_sel, .panel_pos,
		.serial_bit_control_command, .cmd_sel, .cmd_pos,
		.switch_name_label, .switch_off_label, .switch_on_label,
		.switch_pulse_label, .settings_load, .panel_switch_bit,
		.serial_switch_bit, .interval_tick, .restore_busy);

	cmd_source u_cmd_source
		(.sys_clk, .panel_req, .panel_sel, .panel_pos,
		.serial_bit_control_command, .cmd_sel, .cmd_pos);

	task chk(input string w, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", w, e, g);
		end
	endtask : chk

	task test_done;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// past the next tick edge, so outputs have settled
	task nt;
		int i;
		i = 0;
		do
		begin
			@(negedge sys_clk);
			i++;
		end
		while (interval_tick !== 1'h1 && i < 40);
		chk("tick seen", 16'h0001, {15'h0, interval_tick});
		@(negedge sys_clk);
	endtask : nt

	task wait_ready;
		int i;
		for (i = 0; i < 40 && restore_busy !== 1'h0; i++)
			@(negedge sys_clk);
		chk("restore done", 16'h0000, {15'h0, restore_busy});
	endtask : wait_ready

	// l is {name, off, on, pulse}
	task cfg(input int i, input logic [3:0] l);
		@(posedge sys_clk);
		switch_name_label[i] <= l[3];
		switch_off_label[i] <= l[2];
		switch_on_label[i] <= l[1];
		switch_pulse_label[i] <= l[0];
		settings_load <= 1'h1;
		@(posedge sys_clk);
		settings_load <= 1'h0;
		@(negedge sys_clk);
	endtask : cfg

	task t_remote;
		u_cmd_source.send(4'h3, POS_ON);
		nt;
		chk("rem on", 16'h0008, serial_switch_bit);
		u_cmd_source.send(4'hF, POS_MOM);
		nt;
		chk("rem mom", 16'h8008, serial_switch_bit);
		nt;
		chk("rem mom end", 16'h0008, serial_switch_bit);
		u_cmd_source.send(4'h3, POS_OFF);
		nt;
		chk("rem off", 16'h0000, serial_switch_bit);
		u_cmd_source.send(4'h3, POS_ON);
		u_cmd_source.send(4'h3, POS_BAD);
		nt;
		chk("rem bad pos", 16'h0008, serial_switch_bit);
	endtask : t_remote

	task t_panel;
		u_cmd_source.press(4'h0, POS_ON);
		u_cmd_source.press(4'h1, POS_ON);
		u_cmd_source.press(4'h3, POS_ON);
		u_cmd_source.press(4'h2, POS_MOM);
		nt;
		chk("loc mix", 16'h0005, panel_switch_bit);
		chk("rem kept", 16'h0008, serial_switch_bit);
		nt;
		chk("loc mom end", 16'h0001, panel_switch_bit);
		u_cmd_source.press(4'h1, POS_MOM);
		nt;
		chk("loc mom 1", 16'h0003, panel_switch_bit);
		nt;
		chk("loc mom 1 end", 16'h0001, panel_switch_bit);
	endtask : t_panel

	task t_settings;
		cfg(0, 4'hE);
		nt;
		chk("loc same cfg", 16'h0001, panel_switch_bit);
		chk("rem same cfg", 16'h0008, serial_switch_bit);
		cfg(0, 4'h0);
		chk("loc blanked", 16'h0000, panel_switch_bit);
		u_cmd_source.press(4'h0, POS_ON);
		nt;
		chk("loc disabled", 16'h0000, panel_switch_bit);
		cfg(0, 4'hE);
		nt;
		chk("loc new", 16'h0000, panel_switch_bit);
		chk("rem new cfg", 16'h0008, serial_switch_bit);
	endtask : t_settings

	// clock enable low freezes state, so a command then is dropped
	task t_freeze;
		nt;
		@(posedge sys_clk);
		clk_en <= 1'h0;
		u_cmd_source.send(4'h5, POS_ON);
		repeat (20) @(negedge sys_clk);
		chk("rem frozen", 16'h0008, serial_switch_bit);
		@(posedge sys_clk);
		clk_en <= 1'h1;
		nt;
		chk("rem thawed", 16'h0008, serial_switch_bit);
	endtask : t_freeze

	task t_power;
		u_cmd_source.press(4'h2, POS_ON);
		nt;
		chk("loc before loss", 16'h0004, panel_switch_bit);
		repeat (20) @(posedge sys_clk);
		rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		wait_ready;
		nt;
		chk("loc restored", 16'h0004, panel_switch_bit);
		chk("rem cleared", 16'h0000, serial_switch_bit);
	endtask : t_power

	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		wait_ready;
		cfg(0, 4'hE);
		cfg(1, 4'hD);
		cfg(2, 4'hF);
		t_remote;
		t_panel;
		t_settings;
		t_freeze;
		t_power;
		test_done;
	end

	// whole run needs well under a thousand clocks
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		test_done;
	end
endmodule : local_remote_control_bits_tb
`default_nettype wire
